// file: src/swr_pkg.sv
// Operation
// - host resume command ends the suspended state in SWR_SUSP and SWR_OSC; SWR_CHECK ignores it.
// - low pulse on remote-wake input requests wakeup while suspended.
// - rising edge on incoming-call input requests wakeup while suspended.
// - oscillator stays powered down in suspend, restarted on wake condition.
// - after clock returns, sample firing pin; accept only if confirmed.
// - watchdog is enabled straight out of power-on reset.
// - watchdog expiry resets the wake state machine, its outputs and the watchdog like power-on reset; input synchronisers are not reset.
// - after watchdog reset, boot code restarts the full startup sequence.
package swr_pkg;
	// ==========================================
	// timing
	localparam int CLK_MHZ = 250;
	localparam int WAKE_HOLD_US = 3000;
	localparam int OSC_START_CYC = WAKE_HOLD_US * CLK_MHZ / 2;
	localparam int WDOG_CYC = 32'h0001_0000;
	localparam int CHIPRST_CYC = 32'h0000_0010;
	localparam logic WDOG_EN_RST = 1'b1;

	// ==========================================
	// wake state machine
	typedef enum logic [3:0] {
		SWR_RUN = 4'b0001,
		SWR_SUSP = 4'b0010,
		SWR_OSC = 4'b0100,
		SWR_CHECK = 4'b1000
	} swr_state_t;

	// which wake source fired
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_PIN = 2'h1;
	localparam logic [1:0] SRC_CALL = 2'h2;
endpackage : swr_pkg

// file: src/swr_wake_wdog.sv
`timescale 1ns/1ps
`default_nettype none
module swr_wake_wdog
	import swr_pkg::*;
#(
	parameter int OSC_START = OSC_START_CYC,
	parameter int WDOG_TIMEOUT = WDOG_CYC,
	parameter int CHIPRST_LEN = CHIPRST_CYC
)
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic suspendReq,
	input wire logic hostResume,
	input wire logic remoteWake_n,
	input wire logic incoming_call_line_n,
	input wire logic wdogEnable,
	input wire logic wdogService,
	output logic suspended,
	output logic oscPowerDown,
	output logic wakeAccepted,
	output logic wakeRejected,
	output logic chipReset,
	output logic bootRestart,
	output logic wdogEnabled
);
	// ==========================================
	// input synchronisers
	// reset to the idle pin levels so no false edge follows reset
	logic wakeS1_ff;
	logic wakeS2_ff;
	logic callS1_ff;
	logic callS2_ff;
	logic callPrev_ff;
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			wakeS1_ff <= 1'b1;
			wakeS2_ff <= 1'b1;
			callS1_ff <= 1'b1;
			callS2_ff <= 1'b1;
			callPrev_ff <= 1'b1;
		end
		else
		begin
			wakeS1_ff <= remoteWake_n;
			wakeS2_ff <= wakeS1_ff;
			callS1_ff <= incoming_call_line_n;
			callS2_ff <= callS1_ff;
			callPrev_ff <= callS2_ff;
		end
	end

	wire logic wakeLow = !wakeS2_ff;
	wire logic callRise = callS2_ff && !callPrev_ff;

	// ==========================================
	// wake state machine
	swr_state_t state_ff, nxt_state;
	logic [1:0] src_ff, nxt_src;
	logic [31:0] oscCnt_ff, nxt_oscCnt;
	wire logic oscDone = (oscCnt_ff >= 32'(OSC_START - 1));
	wire logic confirmOk = (src_ff == SRC_PIN) ? wakeLow : callS2_ff;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_src = src_ff;
		nxt_oscCnt = 32'h0000_0000;
		case (state_ff)
			SWR_RUN:
			begin
				nxt_src = SRC_NONE;
				if (suspendReq)
					nxt_state = SWR_SUSP;
			end
			SWR_SUSP:
			begin
				if (hostResume)
					nxt_state = SWR_RUN;
				else if (wakeLow)
				begin
					nxt_src = SRC_PIN;
					nxt_state = SWR_OSC;
				end
				else if (callRise)
				begin
					nxt_src = SRC_CALL;
					nxt_state = SWR_OSC;
				end
			end
			SWR_OSC:
			begin
				nxt_oscCnt = oscCnt_ff + 32'h0000_0001;
				if (hostResume)
					nxt_state = SWR_RUN;
				else if (oscDone)
					nxt_state = SWR_CHECK;
			end
			SWR_CHECK:
			begin
				if (confirmOk)
					nxt_state = SWR_RUN;
				else
				begin
					nxt_src = SRC_NONE;
					nxt_state = SWR_SUSP;
				end
			end
			default:
				nxt_state = SWR_RUN;
		endcase
	end

	// watchdog chip reset clears the wake logic like a power-on reset
	wire logic resetAll = srst || chipReset;
	always_ff @(posedge sys_clk)
	begin
		if (resetAll)
		begin
			state_ff <= SWR_RUN;
			src_ff <= SRC_NONE;
			oscCnt_ff <= 32'h0000_0000;
		end
		else
		begin
			state_ff <= nxt_state;
			src_ff <= nxt_src;
			oscCnt_ff <= nxt_oscCnt;
		end
	end

	// ==========================================
	// result pulses, one cycle after the confirmation sample
	wire logic checking = (state_ff == SWR_CHECK);
	logic accept_ff, reject_ff;
	always_ff @(posedge sys_clk)
	begin
		if (resetAll)
		begin
			accept_ff <= 1'b0;
			reject_ff <= 1'b0;
		end
		else
		begin
			accept_ff <= checking && confirmOk;
			reject_ff <= checking && !confirmOk;
		end
	end
	assign wakeAccepted = accept_ff;
	assign wakeRejected = reject_ff;

	// ==========================================
	// status outputs, taken from the next state so they line up with state_ff
	function automatic logic inSuspend(swr_state_t st);
		return (st == SWR_SUSP) || (st == SWR_OSC) || (st == SWR_CHECK);
	endfunction : inSuspend

	logic susp_ff, oscOff_ff;
	always_ff @(posedge sys_clk)
	begin
		if (resetAll)
		begin
			susp_ff <= 1'b0;
			oscOff_ff <= 1'b0;
		end
		else
		begin
			susp_ff <= inSuspend(nxt_state);
			oscOff_ff <= (nxt_state == SWR_SUSP);
		end
	end
	assign suspended = susp_ff;
	assign oscPowerDown = oscOff_ff;

	// ==========================================
	// watchdog
	logic wdEn_ff, rstAct_ff, boot_ff;
	logic [31:0] wdCnt_ff, rstCnt_ff;
	logic [31:0] nxt_wdCnt, nxt_rstCnt;
	wire logic wdClear = srst || rstAct_ff;
	wire logic wdExpire = wdEn_ff && (wdCnt_ff >= 32'(WDOG_TIMEOUT - 1));
	wire logic rstStart = wdExpire && !rstAct_ff;
	wire logic rstDone = rstAct_ff && (rstCnt_ff >= 32'(CHIPRST_LEN - 1));

	// held at zero while disabled so a re-enable starts a full period
	assign nxt_wdCnt = (wdogService || !wdEn_ff) ? 32'h0000_0000 : wdCnt_ff + 32'h0000_0001;
	assign nxt_rstCnt = rstAct_ff ? rstCnt_ff + 32'h0000_0001 : 32'h0000_0000;

	always_ff @(posedge sys_clk)
	begin
		if (wdClear)
		begin
			wdEn_ff <= WDOG_EN_RST;
			wdCnt_ff <= 32'h0000_0000;
		end
		else
		begin
			wdEn_ff <= wdogEnable;
			wdCnt_ff <= nxt_wdCnt;
		end
	end

	// chip reset stretched to CHIPRST_LEN cycles
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			rstAct_ff <= 1'b0;
			rstCnt_ff <= 32'h0000_0000;
		end
		else
		begin
			rstAct_ff <= rstStart || (rstAct_ff && !rstDone);
			rstCnt_ff <= nxt_rstCnt;
		end
	end

	// boot restart flagged for one cycle as the chip reset lets go
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			boot_ff <= 1'b0;
		else
			boot_ff <= rstDone;
	end

	assign chipReset = rstAct_ff;
	assign bootRestart = boot_ff;
	assign wdogEnabled = wdEn_ff;
endmodule : swr_wake_wdog
`default_nettype wire

// file: tb/swr_properties.sv
`timescale 1ns/1ps
`default_nettype none
module swr_properties(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic suspended,
	input wire logic oscPowerDown,
	input wire logic wakeAccepted,
	input wire logic wakeRejected,
	input wire logic chipReset,
	input wire logic bootRestart,
	input wire logic wdogEnabled
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	sequence longRst;
		chipReset [*8];
	endsequence
	a_osc_off: assert property ($rose(suspended) |-> oscPowerDown)
		else $error("osc on");
	a_acc_src: assert property (wakeAccepted |-> $past(suspended))
		else $error("stray");
	a_acc_once: assert property (wakeAccepted |=> !wakeAccepted && !wakeRejected)
		else $error("long");
	a_rej_back: assert property (wakeRejected |-> ##[0:2] oscPowerDown)
		else $error("no resusp");
	a_rst_len: assert property ($rose(chipReset) |-> longRst)
		else $error("short");
	a_rst_fsm: assert property (chipReset |=> !suspended)
		else $error("fsm kept");
	a_boot_next: assert property ($fell(chipReset) |-> ##[0:1] bootRestart)
		else $error("no boot");
	a_wdog_on: assert property ($fell(srst) |-> wdogEnabled)
		else $error("wdog off");
endmodule : swr_properties
bind swr_wake_wdog swr_properties u_swr_properties(.sys_clk, .srst, .suspended, .oscPowerDown,
	.wakeAccepted, .wakeRejected, .chipReset, .bootRestart, .wdogEnabled);
`default_nettype wire

// file: tb/swr_wake_src.sv
`timescale 1ns/1ps
`default_nettype none
module swr_wake_src(
	input wire logic sys_clk,
	output logic hostResume = 1'b0,
	output logic remoteWake_n = 1'b1,
	output logic incoming_call_line_n = 1'b1
);
	// 0 host, 1 and 3 pin low, 2 call line low then rising at release
	task automatic fire(logic [1:0] kind, int n);
		@(posedge sys_clk);
		hostResume <= kind == 2'h0;
		remoteWake_n <= !kind[0];
		incoming_call_line_n <= kind != 2'h2;
		repeat (n) @(posedge sys_clk);
		{hostResume, remoteWake_n, incoming_call_line_n} <= 3'b011;
	endtask : fire
endmodule : swr_wake_src
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk = 0, srst = 1, suspendReq = 0, wdogService = 0, svcOn = 1, wdogOn = 1;
	logic hostResume, remoteWake_n, incoming_call_line_n, suspended, oscPowerDown;
	logic wakeAccepted, wakeRejected, chipReset, bootRestart, wdogEnabled;
	int miscompares = 0, comparisons = 0, seed = 73888, cyc = 0;
	logic [2:0] expQ[$];
	swr_wake_wdog #(.OSC_START(20), .WDOG_TIMEOUT(50)) u_swr_wake_wdog(.sys_clk, .srst,
		.suspendReq, .hostResume, .remoteWake_n, .incoming_call_line_n, .wdogEnable(wdogOn),
		.wdogService, .suspended, .oscPowerDown, .wakeAccepted, .wakeRejected, .chipReset,
		.bootRestart, .wdogEnabled);
	swr_wake_src u_swr_wake_src(.sys_clk, .hostResume, .remoteWake_n, .incoming_call_line_n);
	initial forever #2 sys_clk = ~sys_clk;
	task automatic check(string what, logic [2:0] exp, logic [2:0] seen);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected %s: expected %0d seen %0d", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic settle();
		for (int i = 0; i < 200 && expQ.size() != 0; i++)
			@(posedge sys_clk);
		repeat (3) @(posedge sys_clk);
	endtask : settle
	// scoreboard: 1 reject, 2 accept, 4 boot
	always @(posedge sys_clk)
	begin
		cyc++;
		wdogService <= svcOn && ($random(seed) & 3) == 0;
		if ((wakeAccepted | wakeRejected | bootRestart) !== 1'b0)
			check("result", expQ.size() ? expQ.pop_front() : 3'h0, {bootRestart, wakeAccepted, wakeRejected});
		if (cyc == 3000)
		begin
			miscompares++;
			end_of_test();
		end
	end
	initial
	begin
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		check("wdog", 3'h1, {2'b00, wdogEnabled});
		u_swr_wake_src.fire(2'h1, 30);
		settle();
		for (int k = 0; k < 4; k++)
		begin
			suspendReq <= 1'b1;
			@(posedge sys_clk);
			suspendReq <= 1'b0;
			@(posedge sys_clk);
			check("suspend", 3'h3, {1'b0, suspended, oscPowerDown});
			if (k != 0)
				expQ.push_back(k == 3 ? 3'h1 : 3'h2);
			u_swr_wake_src.fire(2'(k), k == 3 ? 2 : 30 + ($random(seed) & 7));
			if (k == 0)
				check("resume", 3'h0, {1'b0, suspended, oscPowerDown});
			settle();
		end
		// bus detached, watchdog off and unserviced
		wdogOn <= 1'b0;
		svcOn <= 1'b0;
		repeat (120) @(posedge sys_clk);
		check("detach", 3'h0, {1'b0, chipReset, wdogEnabled});
		wdogOn <= 1'b1;
		expQ.push_back(3'h4);
		settle();
		check("state", 3'h0, {1'b0, chipReset, suspended});
		check("pending", 3'h0, 3'(expQ.size()));
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
